//--- verilog/sac_conv.sv
// successive-approximation sequencer with blanked three-state result outputs
// assumes start/blank and comparator inputs are synchronous to i_clk
`default_nettype none
module sac_conv
  import sac_pkg::*;
(
  input  wire  logic                   i_clk,          // 40 MHz system clock
  input  wire  logic                   i_resetn,       // asynchronous, active low
  input  wire  logic                   i_start_blank,  // high blanks, low converts
  input  wire  logic                   i_comp_below,   // dac sum below input
  input  wire  logic                   i_offset_open,  // high selects bipolar range
  output logic [sac_pkg::DATA_WIDTH-1:0] o_dac_code,   // code driven to the dac
  output logic                         o_bipolar,      // bipolar offset switch on
  output logic                         o_result_valid_n, // low when result shown
  output logic [sac_pkg::DATA_WIDTH-1:0] o_data,       // result lines
  output logic [sac_pkg::DATA_WIDTH-1:0] o_data_oe     // high while lines driven
);
  import sac_pkg::*;

  sac_state_type          state, next_state;            // sequencer state
  logic [7:0]             bit_trial_reg, next_bit_trial_reg; // trial register
  logic [7:0]             bit_mask, next_bit_mask;      // bit under trial
  logic [CNT_WIDTH-1:0]   cnt, next_cnt;                // timing counter
  logic [CNT_WIDTH-1:0]   hi_cnt, next_hi_cnt;          // start/blank high width
  logic                   flag_n, next_flag_n;          // result-valid flag
  sac_out_type            outs, next_outs;              // pin drive
  logic                   bip, next_bip;                // sampled range select

  // next-state logic for the whole sequencer
  always_comb begin
    next_state         = state;
    next_bit_trial_reg = bit_trial_reg;
    next_bit_mask      = bit_mask;
    next_cnt           = cnt;
    next_flag_n        = flag_n;
    next_outs          = outs;
    next_bip           = i_offset_open; // range follows the offset input
    // count high time; saturate so a long blank is not lost
    if (!i_start_blank) begin
      next_hi_cnt = '0;
    end else if (hi_cnt != CNT_WIDTH'(CLEAR_CYCLES)) begin
      next_hi_cnt = hi_cnt + 1'b1;
    end else begin
      next_hi_cnt = hi_cnt;
    end
    case (state)
      SAC_IDLE: begin
        // standby; a low line starts a new conversion, pins untouched
        if (!i_start_blank) begin
          next_state         = SAC_TRIAL;
          next_bit_mask      = 8'h80; // msb first
          next_bit_trial_reg = 8'h80;
          next_cnt           = '0;
        end
      end
      SAC_TRIAL: begin
        // one bit per trial period; high line freezes the sequence
        if (i_start_blank) begin
          next_state = SAC_HOLD;
        end else if (cnt == CNT_WIDTH'(BIT_CYCLES - 1)) begin
          next_cnt = '0;
          // keep bit only when the dac sum is still below the input
          if (!i_comp_below) begin
            next_bit_trial_reg = bit_trial_reg & ~bit_mask;
          end
          if (bit_mask == 8'h01) begin // lsb decided, result stands
            next_state  = SAC_SHOW;
            next_flag_n = 1'b0;
          end else begin
            next_bit_mask      = bit_mask >> 1;
            next_bit_trial_reg = (i_comp_below ? bit_trial_reg : (bit_trial_reg & ~bit_mask))
                                 | (bit_mask >> 1);
          end
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      SAC_HOLD: begin
        // stopped; a long enough pulse clears, a short one resumes
        if (hi_cnt == CNT_WIDTH'(CLEAR_CYCLES)) begin
          next_state         = SAC_IDLE;
          next_bit_trial_reg = RESULT_RESET;
          next_bit_mask      = '0;
        end else if (!i_start_blank) begin
          next_state = SAC_TRIAL;
        end
      end
      SAC_SHOW: begin
        // flag went low last cycle; drive pins at once, well inside the limit
        next_outs.data = bit_trial_reg;
        next_outs.oe   = 8'hFF;
        next_state     = SAC_DONE;
      end
      SAC_DONE: begin
        // result presented until start/blank goes high
        if (i_start_blank) begin
          next_state = SAC_BLANK;
          next_cnt   = '0;
        end
      end
      SAC_BLANK: begin
        // delayed release of flag and outputs
        if (cnt == CNT_WIDTH'(BLANK_CYCLES - 1)) begin
          next_flag_n        = 1'b1;
          next_outs.oe       = 8'h00;
          next_bit_trial_reg = RESULT_RESET;
          next_bit_mask      = '0;
          next_cnt           = '0;
          next_state         = SAC_IDLE;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      default: begin
        next_state = SAC_IDLE;
      end
    endcase
  end

  // registers only; constants under reset
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state         <= SAC_IDLE;
      bit_trial_reg <= RESULT_RESET;
      bit_mask      <= '0;
      cnt           <= '0;
      hi_cnt        <= '0;
      flag_n        <= 1'b1;
      outs          <= '0;
      bip           <= 1'b0;
    end else begin
      state         <= next_state;
      bit_trial_reg <= next_bit_trial_reg;
      bit_mask      <= next_bit_mask;
      cnt           <= next_cnt;
      hi_cnt        <= next_hi_cnt;
      flag_n        <= next_flag_n;
      outs          <= next_outs;
      bip           <= next_bip;
    end
  end

  // codes are plain binary in both ranges; bipolar shifts the analog zero
  assign o_dac_code       = bit_trial_reg;
  assign o_bipolar        = bip;
  assign o_result_valid_n = flag_n;
  assign o_data           = outs.data;
  assign o_data_oe        = outs.oe;

  // msb is the first bit tried
  property p_msb_first;
    @(posedge i_clk) disable iff (!i_resetn)
      (state == SAC_IDLE && !i_start_blank) |=> (bit_trial_reg == BIPOLAR_ZERO);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("msb not tried first");

  // a failed trial clears the bit under test
  property p_clear_bit;
    @(posedge i_clk) disable iff (!i_resetn)
      (state == SAC_TRIAL && !i_start_blank && cnt == CNT_WIDTH'(BIT_CYCLES - 1)
       && !i_comp_below) |=> ((bit_trial_reg & $past(bit_mask)) == 8'h00);
  endproperty
  a_clear_bit: assert property (p_clear_bit) else $error("bit kept after failed trial");

  // a passed trial keeps the bit
  property p_keep_bit;
    @(posedge i_clk) disable iff (!i_resetn)
      (state == SAC_TRIAL && !i_start_blank && cnt == CNT_WIDTH'(BIT_CYCLES - 1)
       && i_comp_below) |=> ((bit_trial_reg & $past(bit_mask)) != 8'h00);
  endproperty
  a_keep_bit: assert property (p_keep_bit) else $error("bit dropped after passed trial");

  // shown data equals the final trial register
  property p_result;
    @(posedge i_clk) disable iff (!i_resetn)
      (state == SAC_SHOW) |=> (o_data == $past(bit_trial_reg) && o_data_oe == 8'hFF);
  endproperty
  a_result: assert property (p_result) else $error("result not presented");

  // flag falls, then data drives within the limit
  sequence s_flag_fall;
    $fell(o_result_valid_n);
  endsequence
  property p_data_after_flag;
    @(posedge i_clk) disable iff (!i_resetn)
      s_flag_fall |-> ##[1:20] (o_data_oe == 8'hFF);
  endproperty
  a_data_after_flag: assert property (p_data_after_flag) else $error("data late");

  // outputs never drive while the flag is high
  property p_oe_flag;
    @(posedge i_clk) disable iff (!i_resetn)
      (o_data_oe != 8'h00) |-> !o_result_valid_n;
  endproperty
  a_oe_flag: assert property (p_oe_flag) else $error("outputs driven with flag high");

  // cycles since start/blank was seen high with the result shown; a small counter
  // watches the long blank delay instead of a long repetition in a property
  logic [CNT_WIDTH-1:0]   rel_age, next_rel_age;        // blank delay watch

  // next value of the watch counter; it returns to zero once the delay has run out
  always_comb begin
    next_rel_age = '0;
    if (state == SAC_DONE && i_start_blank) begin
      next_rel_age = CNT_WIDTH'(1);
    end else if (rel_age != '0 && rel_age != CNT_WIDTH'(BLANK_CYCLES)) begin
      next_rel_age = rel_age + 1'b1;
    end
  end

  // watch counter register only
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rel_age <= '0;
    end else begin
      rel_age <= next_rel_age;
    end
  end

  // flag stays low through the whole blank delay
  property p_release_wait;
    @(posedge i_clk) disable iff (!i_resetn)
      (rel_age != '0) |-> !o_result_valid_n;
  endproperty
  a_release_wait: assert property (p_release_wait) else $error("flag released early");

  // release follows the blank delay exactly
  sequence s_released;
    o_result_valid_n && o_data_oe == 8'h00;
  endsequence
  property p_release;
    @(posedge i_clk) disable iff (!i_resetn)
      (rel_age == CNT_WIDTH'(BLANK_CYCLES)) |=> s_released;
  endproperty
  a_release: assert property (p_release) else $error("release timing wrong");

  // start from standby leaves the pins alone
  property p_start_quiet;
    @(posedge i_clk) disable iff (!i_resetn)
      (state == SAC_IDLE && !i_start_blank) |=> (o_result_valid_n && o_data_oe == 8'h00);
  endproperty
  a_start_quiet: assert property (p_start_quiet) else $error("pins moved on start");

  // stopped conversion keeps flag and line enables
  property p_hold_stable;
    @(posedge i_clk) disable iff (!i_resetn)
      (state == SAC_HOLD) |-> ($stable(o_result_valid_n) && $stable(o_data_oe));
  endproperty
  a_hold_stable: assert property (p_hold_stable) else $error("pins moved while stopped");

  // range select follows the offset input
  property p_range;
    @(posedge i_clk) disable iff (!i_resetn)
      1'b1 |=> (o_bipolar == $past(i_offset_open));
  endproperty
  a_range: assert property (p_range) else $error("range select wrong");
endmodule
`default_nettype wire

//--- verilog/sac_pkg.sv
// package for the successive-approximation conversion sequencer
// assumes a 40 MHz system clock and an external comparator decision input
`default_nettype none
package sac_pkg;
  localparam int          CLK_PERIOD_NS   = 25;      // system clock period
  localparam int          DATA_WIDTH      = 8;       // result width in bits
  localparam int          BIT_TIME_NS     = 3000;    // time given to one bit trial
  localparam int          BIT_CYCLES      = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          OUT_DELAY_NS    = 500;     // longest flag-to-data delay
  localparam int          OUT_CYCLES      = OUT_DELAY_NS / CLK_PERIOD_NS;
  localparam int          BLANK_DELAY_NS  = 1500;    // flag release after start/blank high
  localparam int          BLANK_CYCLES    = BLANK_DELAY_NS / CLK_PERIOD_NS;
  localparam int          CLEAR_PULSE_NS  = 2000;    // least high pulse that clears
  localparam int          CLEAR_CYCLES    = (CLEAR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_WIDTH       = 8;       // wide enough for every count above
  localparam logic [7:0]  RESULT_RESET    = 8'h00;   // trial register after reset
  localparam logic [7:0]  BIPOLAR_ZERO    = 8'h80;   // code at zero input, bipolar

  // sequencer states
  typedef enum logic [2:0] {
    SAC_IDLE,
    SAC_TRIAL,
    SAC_HOLD,
    SAC_SHOW,
    SAC_DONE,
    SAC_BLANK
  } sac_state_type;

  // result bus as carried to the pins
  typedef struct packed {
    logic [7:0] data;   // result code
    logic [7:0] oe;     // per-line output enable
  } sac_out_type;
endpackage
`default_nettype wire

//--- tb/sac_comp_model.sv
// comparator stand-in facing the sequencer's dac code
// assumes the analog input is given as a level in lsb steps
`default_nettype none
module sac_comp_model
  import sac_pkg::*;
(
  input  wire logic [7:0] i_dac_code, // trial code from the sequencer
  input  wire logic [7:0] i_level,    // analog input in lsb steps
  output logic            o_below     // high while the dac sum does not pass the input
);
  timeunit 1ns;
  timeprecision 1ps;
  // equal counts as below so the search settles on the level itself
  assign o_below = (i_dac_code <= i_level);
endmodule
`default_nettype wire

//--- tb/test_sar_adc_conversion_control.sv
// self-checking bench for the conversion sequencer and its blanked outputs
// assumes the comparator model in sac_comp_model and the package constants
`default_nettype none
module test_sar_adc_conversion_control
  import sac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk;         // 40 MHz bench clock
  logic       resetn;      // active low reset
  logic       start_blank; // host line: high blanks, low converts
  logic       offset_open; // high selects bipolar
  logic [7:0] level;       // analog input in lsb steps
  logic       comp_below;  // comparator decision
  logic [7:0] dac_code;    // trial register as seen by the dac
  logic       bipolar;     // offset switch
  logic       valid_n;     // result flag, active low
  logic [7:0] data;        // result lines
  logic [7:0] oe;          // line enables
  int         mismatches;  // failed comparisons
  int         checked;     // comparisons made

  sac_conv dut (.i_clk(clk), .i_resetn(resetn), .i_start_blank(start_blank),
    .i_comp_below(comp_below), .i_offset_open(offset_open), .o_dac_code(dac_code),
    .o_bipolar(bipolar), .o_result_valid_n(valid_n), .o_data(data), .o_data_oe(oe));
  sac_comp_model cmp (.i_dac_code(dac_code), .i_level(level), .o_below(comp_below));

  // half period of 12.5 ns
  always #12.5 clk = ~clk;

  task automatic summarize;
    if (mismatches == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // case equality so an unknown never passes
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // inputs always move 2 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // bounded wait for the flag to reach a level, counting cycles
  task automatic wait_flag(input logic lvl, output int n);
    n = 0;
    while (valid_n !== lvl && n < 1200) begin
      tick(1);
      n++;
    end
  endtask

  // one whole conversion; codes are plain binary in both ranges
  task automatic t_convert(input logic [7:0] v, input logic bip);
    int n;
    level = v;
    offset_open = bip;
    start_blank = 1'b0;
    tick(2);
    chk(dac_code, 8'h80);
    chk({7'h0, valid_n}, 8'h01);
    chk(oe, 8'h00);
    wait_flag(1'b0, n);
    chk({7'h0, n > 900 && n < 1000}, 8'h01);
    tick(1);
    chk(data, v);
    chk(oe, 8'hFF);
    chk({7'h0, bipolar}, {7'h0, bip});
  endtask

  // blank: flag released about 1.5 us later, lines float, register ready
  task automatic t_release;
    int n;
    start_blank = 1'b1;
    wait_flag(1'b1, n);
    chk({7'h0, n > 57 && n < 65}, 8'h01);
    chk(oe, 8'h00);
    chk(dac_code, 8'h00);
    tick(3);
  endtask

  // short high pauses a conversion, a long one clears and restarts it
  task automatic t_abort;
    int n;
    level = 8'h5A;
    start_blank = 1'b0;
    tick(300);
    start_blank = 1'b1;
    tick(20);
    chk({7'h0, valid_n}, 8'h01);
    chk(oe, 8'h00);
    start_blank = 1'b0;
    wait_flag(1'b0, n);
    chk({7'h0, n > 600 && n < 700}, 8'h01);
    tick(1);
    chk(data, 8'h5A);
    t_release;
    start_blank = 1'b0;
    tick(300);
    start_blank = 1'b1;
    tick(100);
    chk(dac_code, 8'h00);
    start_blank = 1'b0;
    wait_flag(1'b0, n);
    chk({7'h0, n > 900 && n < 1000}, 8'h01);
    tick(1);
    chk(data, 8'h5A);
    t_release;
  endtask

  // main sequence
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    start_blank = 1'b1;
    offset_open = 1'b0;
    level = 8'h00;
    mismatches = 0;
    checked = 0;
    tick(12);
    resetn = 1'b1;
    chk({7'h0, valid_n}, 8'h01);
    chk(oe, 8'h00);
    t_convert(8'hFF, 1'b0);
    t_release;
    t_convert(8'h00, 1'b1);
    t_release;
    t_convert(8'h80, 1'b1);
    t_release;
    t_convert(8'hFF, 1'b1);
    t_release;
    t_convert(8'h35, 1'b0);
    t_release;
    t_abort;
    summarize;
  end

  // watchdog: the run needs under 10000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    summarize;
  end
endmodule
`default_nettype wire
